// ---- shared/osc_consts.svh ----
// Constants of the single-conversion configuration command handler
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH

// ****************************************************************
// Command and pointer codes
// ****************************************************************
`define OSC_CMD_START_CONV   8'h51
`define OSC_CMD_STOP_CONV    8'h22
`define OSC_CMD_COPY_DATA    8'h48
`define OSC_PTR_CFG_HIGH     8'hac

// ****************************************************************
// Configuration high byte layout and reset value
// ****************************************************************
`define OSC_CFG_MODE_BIT     0
`define OSC_CFG_NVB_BIT      3
`define OSC_CFG_RESET        8'h00
`define OSC_NV_RESET         8'h00

// ****************************************************************
// Address byte layout
// ****************************************************************
`define OSC_ADDR_RW_BIT      0
`define OSC_ADDR_WRITE       1'b0

// ****************************************************************
// Timing
// ****************************************************************
`define OSC_CLK_HZ           50000000
`define OSC_NV_COPY_TIME_MS  10
`define OSC_NV_COPY_CYCLES   ((`OSC_NV_COPY_TIME_MS * `OSC_CLK_HZ) / 1000)
`define OSC_CONV_CYCLES      1000

`endif

// ---- shared/osc_pkg.sv ----
// Types of the single-conversion configuration command handler
`default_nettype none
package osc_pkg;

    typedef enum logic [1:0] {
        OSC_LK_IDLE  = 2'b00,
        OSC_LK_ADDR  = 2'b01,
        OSC_LK_WRITE = 2'b10,
        OSC_LK_READ  = 2'b11
    } osc_link_state_t;

    typedef enum logic [0:0] {
        OSC_NV_IDLE = 1'b0,
        OSC_NV_BUSY = 1'b1
    } osc_nv_state_t;

endpackage : osc_pkg
`default_nettype wire

// ---- hdl/osc_nv_store.sv ----
// Nonvolatile copy engine: shadow byte into nonvolatile storage
`timescale 1ns/1ps
`default_nettype none
`include "osc_consts.svh"

module osc_nv_store
    import osc_pkg::*;
#(
    parameter int COPY_CYCLES = `OSC_NV_COPY_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       copy_req,
    input  wire logic [7:0] shadow,
    output logic            busy,
    output logic [7:0]      nv_byte
);

    localparam int CW = $clog2(COPY_CYCLES + 1);

    osc_nv_state_t  state_q;
    logic [CW-1:0]  count_q;
    logic [7:0]     latch_q;

    // ****************************************************************
    // Copy sequencing
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= OSC_NV_IDLE;
            count_q <= '0;
            latch_q <= `OSC_NV_RESET;
            nv_byte <= `OSC_NV_RESET;
        end else begin
            unique case (state_q)
                OSC_NV_IDLE: begin
                    if (copy_req) begin
                        state_q <= OSC_NV_BUSY;
                        latch_q <= shadow;
                        count_q <= CW'(COPY_CYCLES - 1);
                    end
                end
                OSC_NV_BUSY: begin
                    if (count_q == '0) begin
                        nv_byte <= latch_q;
                        state_q <= OSC_NV_IDLE;
                    end else begin
                        count_q <= count_q - CW'(1);
                    end
                end
            endcase
        end
    end

    assign busy = (state_q == OSC_NV_BUSY);

endmodule : osc_nv_store

`default_nettype wire

// ---- hdl/osc_cmd_slave.sv ----
// Two-wire slave command handler for conversion mode configuration
`timescale 1ns/1ps
`default_nettype none
`include "osc_consts.svh"

module osc_cmd_slave
    import osc_pkg::*;
#(
    parameter int CONV_CYCLES    = `OSC_CONV_CYCLES,
    parameter int NV_COPY_CYCLES = `OSC_NV_COPY_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       scl,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic [6:0] dev_addr,
    output logic            converting,
    output logic            single_conversion_mode_bit,
    output logic            nonvolatile_busy_flag,
    output logic [7:0]      nv_config
);

    localparam int TW = $clog2(CONV_CYCLES + 1);

    // ****************************************************************
    // Link domain signals
    // ****************************************************************
    osc_link_state_t lk_state_q;
    logic [3:0]      bit_cnt_q;
    logic [7:0]      shift_q;
    logic [7:0]      tx_q;
    logic            drive_q;
    logic            sda_pos_q;
    logic            start_tgl_q;
    logic            start_seen_q;
    logic            first_q;
    logic [7:0]      rx_byte_q;
    logic            rx_first_q;
    logic            rx_tgl_q;
    logic            lrst_s1_q;
    logic            lrst_s2_q;
    logic [6:0]      addr_s1_q;
    logic [6:0]      addr_s2_q;
    logic [7:0]      cfg_s1_q;
    logic [7:0]      cfg_s2_q;
    logic [7:0]      byte_in;

    // ****************************************************************
    // System domain signals
    // ****************************************************************
    logic            rx_s1_q;
    logic            rx_s2_q;
    logic            rx_s3_q;
    logic            rx_event;
    logic            ptr_cfg_q;
    logic [7:0]      shadow_q;
    logic            copy_req_q;
    logic            continuous_q;
    logic [TW-1:0]   conv_cnt_q;
    logic            nv_busy;
    logic [7:0]      cfg_read;

    function automatic logic [7:0] osc_cfg_view(input logic [7:0] sh, input logic busy);
        logic [7:0] v;
        v = sh;
        v[`OSC_CFG_NVB_BIT] = busy;
        return v;
    endfunction : osc_cfg_view

    // ****************************************************************
    // Link domain: START marker
    // ****************************************************************
    // SDA falling while SCL is high toggles the marker; the SCL side
    // sees it at the next falling SCL edge, when it has long settled.
    // Cleared while the link side is held in reset so it never starts unknown.
    always_ff @(negedge sda_i or posedge lrst_s2_q) begin
        if (lrst_s2_q) begin
            start_tgl_q <= 1'b0;
        end else if (scl) begin
            start_tgl_q <= ~start_tgl_q;
        end
    end

    // ****************************************************************
    // Link domain: bit sampling on rising SCL
    // ****************************************************************
    always_ff @(posedge scl) begin
        sda_pos_q <= sda_i;
    end

    // ****************************************************************
    // Link domain: reset, address and readback synchronisers
    // ****************************************************************
    always_ff @(negedge scl) begin
        lrst_s1_q <= reset;
        lrst_s2_q <= lrst_s1_q;
        addr_s1_q <= dev_addr;
        addr_s2_q <= addr_s1_q;
        cfg_s1_q  <= cfg_read;
        cfg_s2_q  <= cfg_s1_q;
    end

    assign byte_in = {shift_q[6:0], sda_pos_q};

    // ****************************************************************
    // Link domain: byte engine on falling SCL
    // ****************************************************************
    always_ff @(negedge scl) begin
        if (lrst_s2_q) begin
            lk_state_q   <= OSC_LK_IDLE;
            bit_cnt_q    <= 4'h0;
            shift_q      <= 8'h00;
            tx_q         <= 8'h00;
            drive_q      <= 1'b0;
            start_seen_q <= start_tgl_q;
            first_q      <= 1'b0;
            rx_byte_q    <= 8'h00;
            rx_first_q   <= 1'b0;
            rx_tgl_q     <= 1'b0;
        end else if (start_tgl_q != start_seen_q) begin
            start_seen_q <= start_tgl_q;
            lk_state_q   <= OSC_LK_ADDR;
            bit_cnt_q    <= 4'h0;
            drive_q      <= 1'b0;
        end else if (bit_cnt_q == 4'h7) begin
            bit_cnt_q <= 4'h8;
            shift_q   <= byte_in;
            drive_q   <= 1'b0;
            unique case (lk_state_q)
                OSC_LK_ADDR: begin
                    if (byte_in[7:1] == addr_s2_q) begin
                        drive_q    <= 1'b1;
                        first_q    <= 1'b1;
                        lk_state_q <= (byte_in[`OSC_ADDR_RW_BIT] == `OSC_ADDR_WRITE) ?
                                      OSC_LK_WRITE : OSC_LK_READ;
                    end else begin
                        lk_state_q <= OSC_LK_IDLE;
                    end
                end
                OSC_LK_WRITE: begin
                    drive_q    <= 1'b1;
                    rx_byte_q  <= byte_in;
                    rx_first_q <= first_q;
                    first_q    <= 1'b0;
                    rx_tgl_q   <= ~rx_tgl_q;
                end
                OSC_LK_IDLE, OSC_LK_READ: begin
                    drive_q <= 1'b0;
                end
            endcase
        end else if (bit_cnt_q == 4'h8) begin
            bit_cnt_q <= 4'h0;
            drive_q   <= 1'b0;
            if (lk_state_q == OSC_LK_READ) begin
                // Low here is our own address ack or the master's ack
                if (!sda_pos_q) begin
                    drive_q <= ~cfg_s2_q[7];
                    tx_q    <= {cfg_s2_q[6:0], 1'b0};
                end else begin
                    lk_state_q <= OSC_LK_IDLE;
                end
            end
        end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            shift_q   <= byte_in;
            if (lk_state_q == OSC_LK_READ) begin
                drive_q <= ~tx_q[7];
                tx_q    <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // Open drain: only ever pulls low
    assign sda_o  = 1'b0;
    assign sda_oe = drive_q & ~reset;

    // ****************************************************************
    // System domain: received byte event
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_s1_q <= 1'b0;
            rx_s2_q <= 1'b0;
            rx_s3_q <= 1'b0;
        end else begin
            rx_s1_q <= rx_tgl_q;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
        end
    end

    assign rx_event = rx_s2_q ^ rx_s3_q;

    // ****************************************************************
    // System domain: pointer and shadow byte
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            ptr_cfg_q <= 1'b0;
            shadow_q  <= `OSC_CFG_RESET;
        end else if (rx_event) begin
            if (rx_first_q) begin
                ptr_cfg_q <= (rx_byte_q == `OSC_PTR_CFG_HIGH);
            end else if (ptr_cfg_q) begin
                shadow_q <= rx_byte_q;
            end
        end
    end

    assign single_conversion_mode_bit = shadow_q[`OSC_CFG_MODE_BIT];

    // ****************************************************************
    // System domain: commands
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            copy_req_q <= 1'b0;
        end else begin
            copy_req_q <= rx_event && rx_first_q && (rx_byte_q == `OSC_CMD_COPY_DATA);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            continuous_q <= 1'b0;
            conv_cnt_q   <= '0;
        end else if (rx_event && rx_first_q && rx_byte_q == `OSC_CMD_START_CONV) begin
            if (single_conversion_mode_bit) begin
                conv_cnt_q <= TW'(CONV_CYCLES);
            end else begin
                continuous_q <= 1'b1;
            end
        end else if (rx_event && rx_first_q && rx_byte_q == `OSC_CMD_STOP_CONV) begin
            continuous_q <= 1'b0;
            conv_cnt_q   <= '0;
        end else if (conv_cnt_q != '0) begin
            conv_cnt_q <= conv_cnt_q - TW'(1);
        end
    end

    assign converting = continuous_q | (conv_cnt_q != '0);

    // ****************************************************************
    // Nonvolatile storage
    // ****************************************************************
    osc_nv_store #(
        .COPY_CYCLES (NV_COPY_CYCLES)
    ) u_nv (
        .clk      (clk),
        .reset    (reset),
        .copy_req (copy_req_q),
        .shadow   (shadow_q),
        .busy     (nv_busy),
        .nv_byte  (nv_config)
    );

    assign nonvolatile_busy_flag = nv_busy;
    assign cfg_read              = osc_cfg_view(shadow_q, nv_busy);

endmodule : osc_cmd_slave

`default_nettype wire

// ---- tb/osc_cmd_checker_assertions.sv ----
// Port assertions for the command handler
`timescale 1ns/1ps
`default_nettype none
module osc_cmd_checker
    import osc_pkg::*;
#(parameter int NV_COPY_CYCLES = 20) (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       scl,
    input wire logic       sda_i,
    input wire logic       sda_oe,
    input wire logic [6:0] dev_addr,
    input wire logic       converting,
    input wire logic       single_conversion_mode_bit,
    input wire logic       nonvolatile_busy_flag,
    input wire logic [7:0] nv_config
);
    logic       st_q = 1'b0, seen_q = 1'b0, wr_q = 1'b0;
    logic [7:0] bits_q = 8'hff, sh_q = 8'h00;
    logic [1:0] sc_q = 2'b00;
    logic [4:0] idle_q = 5'h1f;
    int         busy_q = 0;
    // Toggles on every start marker
    always_ff @(negedge sda_i) if (scl) st_q <= ~st_q;
    // Bit position since the last start, saturating when idle
    always_ff @(posedge scl) begin
        seen_q <= st_q;
        sh_q   <= {sh_q[6:0], sda_i};
        bits_q <= (seen_q != st_q) ? 8'h01 : bits_q + {7'h00, bits_q != 8'hff};
        if (bits_q == 8'h08) wr_q <= (sh_q == {dev_addr, 1'b0});
    end
    always_ff @(posedge clk) begin
        sc_q   <= {sc_q[0], scl};
        idle_q <= (sc_q[1] != sc_q[0]) ? 5'h00 : idle_q + {4'h0, idle_q != 5'h1f};
        busy_q <= (reset || !nonvolatile_busy_flag) ? 0 : busy_q + 1;
    end
    addr_ack_a: assert property (@(posedge scl) disable iff (reset)
        bits_q == 8'h08 |-> sda_oe == (sh_q[7:1] == dev_addr))
        else $error("address acknowledge wrong");
    addr_quiet_a: assert property (@(posedge scl) disable iff (reset)
        bits_q < 8'h08 |-> !sda_oe) else $error("data line driven in address");
    data_ack_a: assert property (@(posedge scl) disable iff (reset)
        wr_q && bits_q inside {8'h11, 8'h1a} |-> sda_oe) else $error("byte not acknowledged");
    cmd_quiet_a: assert property (@(posedge scl) disable iff (reset)
        wr_q && bits_q inside {[8'h09:8'h10]} |-> !sda_oe) else $error("data line driven in command");
    nv_commit_a: assert property (@(posedge clk) disable iff (reset)
        $changed(nv_config) |-> $fell(nonvolatile_busy_flag)) else $error("stored byte changed early");
    nv_copy_a: assert property (@(posedge clk) disable iff (reset)
        $fell(nonvolatile_busy_flag) |-> nv_config[0] == single_conversion_mode_bit)
        else $error("stored byte differs from shadow");
    busy_len_a: assert property (@(posedge clk) disable iff (reset)
        $fell(nonvolatile_busy_flag) |-> busy_q inside {[NV_COPY_CYCLES:NV_COPY_CYCLES + 1]})
        else $error("busy flag length wrong");
    mode_cause_a: assert property (@(posedge clk) disable iff (reset)
        $changed(single_conversion_mode_bit) |-> idle_q < 5'h0c) else $error("mode changed unasked");
    conv_cause_a: assert property (@(posedge clk) disable iff (reset)
        $rose(converting) |-> idle_q < 5'h0c) else $error("conversion started unasked");
    cover property (@(posedge clk) $rose(nonvolatile_busy_flag));
    cover property (@(posedge clk) $fell(converting));
    cover property (@(posedge scl) bits_q == 8'h08 && sda_oe);
endmodule : osc_cmd_checker
`default_nettype wire

// ---- tb/osc_link_master.sv ----
// Two-wire bus master model for the command handler
`timescale 1ns/1ps
`default_nettype none
module osc_link_master (
    output logic      scl,
    output logic      sda_oe,
    input  wire logic sda
);
    initial begin
        scl    = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic bit_io(input logic b, output logic s);
        sda_oe = ~b;
        #8 scl = 1'b1;
        s = sda;
        #15 scl = 1'b0;
        #7;
    endtask : bit_io
    task automatic start();
        sda_oe = 1'b0;
        #8 scl = 1'b1;
        #7 sda_oe = 1'b1;
        #8 scl = 1'b0;
        #7;
    endtask : start
    task automatic stop();
        sda_oe = 1'b1;
        #8 scl = 1'b1;
        #7 sda_oe = 1'b0;
        #8;
    endtask : stop
    // Free clocks with the line released, used to clock the link side through and out of reset
    task automatic idle(input int n);
        repeat (n) begin
            #15 scl = 1'b0;
            #15 scl = 1'b1;
        end
    endtask : idle
    task automatic wr(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, ack);
    endtask : wr
    task automatic rd(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, s);
    endtask : rd
endmodule : osc_link_master
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the command handler
`timescale 1ns/1ps
`default_nettype none
module tb_top import osc_pkg::*;;
    localparam logic [6:0] ADDR = 7'h2a;
    logic       clk, reset, scl, sda, sda_o, sda_oe, m_oe, conv, mode, busy, ack;
    logic [7:0] nv, d;
    int         fails = 0, num_checks = 0, cycles = 0;
    // Pull-up on the data line
    assign sda = ~((sda_oe & ~sda_o) | m_oe);
    osc_cmd_slave #(.CONV_CYCLES(10), .NV_COPY_CYCLES(60)) DUT (
        .clk(clk), .reset(reset), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .dev_addr(ADDR), .converting(conv), .single_conversion_mode_bit(mode),
        .nonvolatile_busy_flag(busy), .nv_config(nv));
    osc_link_master M (.scl(scl), .sda_oe(m_oe), .sda(sda));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic cmd(input logic [6:0] a, input logic [7:0] b0, b1, input bit two);
        M.start();
        M.wr({a, 1'b0}, ack);
        check("address ack", {7'h00, a != ADDR}, {7'h00, ack});
        if (a == ADDR) begin
            M.wr(b0, ack);
            check("command ack", 8'h00, {7'h00, ack});
            if (two) begin
                M.wr(b1, ack);
                check("data ack", 8'h00, {7'h00, ack});
            end
        end
    endtask : cmd
    task automatic rd_cfg();
        M.start();
        M.wr({ADDR, 1'b1}, ack);
        check("read address ack", 8'h00, {7'h00, ack});
        M.rd(d);
    endtask : rd_cfg
    initial begin
        reset = 1'b1;
        fork
            M.idle(3);
            repeat (12) @(negedge clk);
        join
        reset = 1'b0;
        M.idle(3);
        check("reset outputs", 8'h00, {3'h0, sda_o, conv, mode, busy, sda_oe});
        check("reset nv", 8'h00, nv);
        cmd(ADDR ^ 7'h01, 8'h51, 8'h00, 1'b0);
        M.stop();
        repeat (6) @(negedge clk);
        check("converting", 8'h00, {7'h00, conv});
        cmd(ADDR, 8'h51, 8'h00, 1'b0);
        repeat (6) @(negedge clk);
        check("converting", 8'h01, {7'h00, conv});
        cmd(ADDR, 8'hac, 8'hff, 1'b1);
        repeat (6) @(negedge clk);
        check("mode bit", 8'h01, {7'h00, mode});
        check("nv unchanged", 8'h00, nv);
        cmd(ADDR, 8'haa, 8'h00, 1'b1);
        repeat (6) @(negedge clk);
        check("mode bit kept", 8'h01, {7'h00, mode});
        cmd(ADDR, 8'h48, 8'h00, 1'b0);
        repeat (6) @(negedge clk);
        check("busy", 8'h01, {7'h00, busy});
        rd_cfg();
        check("config view", 8'hff, d);
        for (int i = 0; i < 8 && d !== 8'hf7; i++) rd_cfg();
        check("config view", 8'hf7, d);
        check("nv copy", 8'hff, nv);
        cmd(ADDR, 8'h22, 8'h00, 1'b0);
        repeat (6) @(negedge clk);
        check("converting", 8'h00, {7'h00, conv});
        cmd(ADDR, 8'h51, 8'h00, 1'b0);
        repeat (4) @(negedge clk);
        check("converting", 8'h01, {7'h00, conv});
        repeat (20) @(negedge clk);
        check("converting", 8'h00, {7'h00, conv});
        cmd(ADDR, 8'hac, 8'hfe, 1'b1);
        cmd(ADDR, 8'h51, 8'h00, 1'b0);
        repeat (30) @(negedge clk);
        check("mode bit", 8'h00, {7'h00, mode});
        check("converting", 8'h01, {7'h00, conv});
        M.stop();
        close_out();
    end
endmodule : tb_top
bind osc_cmd_slave osc_cmd_checker #(.NV_COPY_CYCLES(NV_COPY_CYCLES)) CHK (
    .clk(clk), .reset(reset), .scl(scl), .sda_i(sda_i), .sda_oe(sda_oe), .dev_addr(dev_addr),
    .converting(converting), .single_conversion_mode_bit(single_conversion_mode_bit),
    .nonvolatile_busy_flag(nonvolatile_busy_flag), .nv_config(nv_config));
`default_nettype wire
